//--- ocdm_div.sv
// 8-bit output divider, code n divides the tick rate by n+1
`timescale 1ns/1ns
module ocdm_div (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // input edge pulses and ratio code
    input wire logic i_tick,
    input wire logic [7:0] i_code,
    // divided pulse
    output logic o_tick
);
    typedef struct packed {
        logic [7:0] count;
        logic tick;
    } ocdm_div_st_t;

    ocdm_div_st_t st;
    ocdm_div_st_t next_st;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (i_tick) begin
            // >= so a code lowered mid-count cannot strand the counter
            if (st.count >= i_code) begin
                next_st.count = 8'h00;
                next_st.tick = 1'b1;
            end else begin
                next_st.count = st.count + 8'h01;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_tick = st.tick;
endmodule // ocdm_div

//--- ocdm_pkg.sv
// constants, types and helpers for the output channel divider and mux slice
package ocdm_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] OCDM_IDX_DIV23 = 8'h24;
    localparam logic [7:0] OCDM_IDX_CTL4 = 8'h25;
    localparam logic [7:0] OCDM_IDX_DIV4 = 8'h26;
    localparam logic [9:0] OCDM_ADDR_DIV23 = {OCDM_IDX_DIV23, 2'b00};
    localparam logic [9:0] OCDM_ADDR_CTL4 = {OCDM_IDX_CTL4, 2'b00};
    localparam logic [9:0] OCDM_ADDR_DIV4 = {OCDM_IDX_DIV4, 2'b00};
    localparam int OCDM_ADDR_W = 10;

    // reset values
    localparam logic [7:0] OCDM_RST_DIV23 = 8'h03;
    localparam logic [7:0] OCDM_RST_DIV4 = 8'h02;
    localparam logic [1:0] OCDM_RST_SRC = 2'h0;
    localparam logic [1:0] OCDM_RST_FMT = 2'h1;
    localparam logic [1:0] OCDM_RST_MODE1 = 2'h2;
    localparam logic [1:0] OCDM_RST_MODE2 = 2'h0;

    // channel four control field positions
    localparam int OCDM_SRC_LSB = 6;
    localparam int OCDM_FMT_LSB = 4;
    localparam int OCDM_MODE1_LSB = 2;
    localparam int OCDM_MODE2_LSB = 0;

    // axi4-lite responses
    localparam logic [1:0] OCDM_RESP_OKAY = 2'h0;
    localparam logic [1:0] OCDM_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        OCDM_SRC_SYNTH1,
        OCDM_SRC_SYNTH2,
        OCDM_SRC_PRI_REF,
        OCDM_SRC_SEC_REF
    } ocdm_src_t;

    typedef enum logic [1:0] {
        OCDM_FMT_OFF,
        OCDM_FMT_AC_DIFF,
        OCDM_FMT_HCSL,
        OCDM_FMT_CMOS
    } ocdm_fmt_t;

    // cmos pin state: {running, invert, tristate}
    localparam logic [1:0] OCDM_PIN_DOWN_Z = 2'h0;
    localparam logic [1:0] OCDM_PIN_DOWN_LOW = 2'h1;
    localparam logic [1:0] OCDM_PIN_RUN_INV = 2'h2;

    function automatic logic [2:0] ocdm_pin_decode(input logic [1:0] code);
        logic [2:0] r;
        r = 3'h0;
        unique case (code)
            OCDM_PIN_DOWN_Z: r = 3'h1;
            OCDM_PIN_DOWN_LOW: r = 3'h0;
            OCDM_PIN_RUN_INV: r = 3'h6;
            default: r = 3'h4;
        endcase
        return r;
    endfunction
endpackage

//--- ocdm_src_mux.sv
// channel four clock source selector with reference doubler
`timescale 1ns/1ns
module ocdm_src_mux (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // source clock levels, sampled on i_clk
    input wire logic i_first_synth_clock,
    input wire logic i_second_synth_clock,
    input wire logic i_pri_ref_clock,
    input wire logic i_sec_ref_clock,
    input wire logic i_ref_doubler_en,
    input wire logic [1:0] i_ch4_source_select,
    // selected edge pulse and bypass flag
    output logic o_tick,
    output logic o_bypass
);
    typedef struct packed {
        logic [3:0] prev;
        logic tick;
        logic bypass;
    } ocdm_mux_st_t;

    ocdm_mux_st_t st;
    ocdm_mux_st_t next_st;

    always_comb begin
        logic [3:0] cur;
        logic [3:0] rise;
        logic [3:0] both;
        cur = {i_sec_ref_clock, i_pri_ref_clock, i_second_synth_clock, i_first_synth_clock};
        rise = cur & ~st.prev;
        both = cur ^ st.prev;
        next_st = st;
        next_st.prev = cur;
        next_st.bypass = 1'b0;
        unique case (ocdm_pkg::ocdm_src_t'(i_ch4_source_select))
            ocdm_pkg::OCDM_SRC_SYNTH1: next_st.tick = rise[0];
            ocdm_pkg::OCDM_SRC_SYNTH2: next_st.tick = rise[1];
            ocdm_pkg::OCDM_SRC_PRI_REF: begin
                // both edges give twice the rate when doubling
                next_st.tick = i_ref_doubler_en ? both[2] : rise[2];
                next_st.bypass = 1'b1;
            end
            ocdm_pkg::OCDM_SRC_SEC_REF: begin
                next_st.tick = i_ref_doubler_en ? both[3] : rise[3];
                next_st.bypass = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_tick = st.tick;
    assign o_bypass = st.bypass;
endmodule // ocdm_src_mux

//--- ocdm_sva.sv
// bus handshake and driver decode assertions for the output channel slice
`timescale 1ns/1ns
module ocdm_sva (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // register bus
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    // channel four
    input wire logic o_ch4_tick,
    input wire logic o_ch4_drv_en,
    input wire logic o_ch4_diff,
    input wire logic o_ch4_hcsl,
    input wire logic o_ch4_cmos,
    input wire logic [1:0] o_ch4_tail_level,
    input wire logic [1:0] o_ch4_hcsl_load,
    input wire logic [2:0] o_ch4_pos_pin,
    input wire logic [2:0] o_ch4_neg_pin
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    chk_wr_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> o_bvalid)
        else $error("write not answered");
    chk_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("write response dropped");
    chk_rd_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read not answered");
    chk_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data not held");
    chk_rd_upper: assert property (o_rvalid |-> !o_arready && o_rdata[31:8] == 24'h0)
        else $error("read channel misbehaves");
    chk_fmt_flags: assert property ($onehot0({o_ch4_diff, o_ch4_hcsl, o_ch4_cmos})
        && o_ch4_drv_en == |{o_ch4_diff, o_ch4_hcsl, o_ch4_cmos})
        else $error("driver format flags inconsistent");
    chk_pin_idle: assert property (!o_ch4_cmos && !$past(o_ch4_cmos)
        |-> o_ch4_pos_pin == 3'h1 && o_ch4_neg_pin == 3'h1)
        else $error("pin state outside cmos format");
    chk_load_idle: assert property (!o_ch4_hcsl && !$past(o_ch4_hcsl) |-> o_ch4_hcsl_load == 2'h0)
        else $error("load set outside hcsl format");
    chk_tail_idle: assert property (!o_ch4_diff && !o_ch4_hcsl && !$past(o_ch4_diff)
        && !$past(o_ch4_hcsl) |-> o_ch4_tail_level == 2'h0)
        else $error("tail current set outside differential format");
    // sources stay below a quarter of the sample rate, so even doubled output pulses never touch
    chk_tick_gap: assert property (o_ch4_tick |=> !o_ch4_tick)
        else $error("channel four pulses adjacent");
endmodule // ocdm_sva

//--- ocdm_top.sv
// channel 2/3 shared divider and channel 4 source, driver and divider control
`timescale 1ns/1ns
module ocdm_top (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // axi4-lite write address
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_awaddr,
    input wire logic [2:0] i_awprot,
    // axi4-lite write data
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // axi4-lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // axi4-lite read address
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [31:0] i_araddr,
    input wire logic [2:0] i_arprot,
    // axi4-lite read data
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // clock sources, levels sampled on i_clk
    input wire logic i_first_synth_clock,
    input wire logic i_second_synth_clock,
    input wire logic i_pri_ref_clock,
    input wire logic i_sec_ref_clock,
    input wire logic i_ref_doubler_en,
    input wire logic i_ch23_src_tick,
    // channel outputs as edge pulses, and the channel four bypass level
    output logic o_ch23_tick,
    output logic o_ch4_tick,
    output logic o_ch4_bypass,
    // channel four driver controls
    output logic o_ch4_drv_en,
    output logic o_ch4_diff,
    output logic o_ch4_hcsl,
    output logic o_ch4_cmos,
    output logic [1:0] o_ch4_tail_level,
    output logic [1:0] o_ch4_hcsl_load,
    output logic [2:0] o_ch4_pos_pin,
    output logic [2:0] o_ch4_neg_pin
);
    typedef struct packed {
        logic [7:0] div23;
        logic [1:0] src;
        logic [1:0] fmt;
        logic [1:0] mode1;
        logic [1:0] mode2;
        logic [7:0] div4;
        logic aw_held;
        logic [9:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic ch4_tick;
        logic [1:0] tail;
        logic [1:0] load;
        logic [2:0] ppin;
        logic [2:0] npin;
    } ocdm_top_st_t;

    ocdm_top_st_t st;
    ocdm_top_st_t next_st;
    logic mux_tick;
    logic mux_bypass;
    logic div4_tick;

    function automatic logic addr_known(input logic [9:0] a);
        return a == ocdm_pkg::OCDM_ADDR_DIV23 || a == ocdm_pkg::OCDM_ADDR_CTL4
            || a == ocdm_pkg::OCDM_ADDR_DIV4;
    endfunction

    ocdm_src_mux u_mux (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_first_synth_clock(i_first_synth_clock),
        .i_second_synth_clock(i_second_synth_clock),
        .i_pri_ref_clock(i_pri_ref_clock),
        .i_sec_ref_clock(i_sec_ref_clock),
        .i_ref_doubler_en(i_ref_doubler_en),
        .i_ch4_source_select(st.src),
        .o_tick(mux_tick),
        .o_bypass(mux_bypass)
    );

    // one divider and one code for both channels two and three
    ocdm_div u_div23 (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_tick(i_ch23_src_tick),
        .i_code(st.div23),
        .o_tick(o_ch23_tick)
    );

    ocdm_div u_div4 (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_tick(mux_tick & ~mux_bypass),
        .i_code(st.div4),
        .o_tick(div4_tick)
    );

    always_comb begin
        logic [9:0] wa;
        logic [9:0] ra;
        logic [7:0] wd;
        wa = st.aw_held ? st.aw_addr : i_awaddr[9:0];
        wd = st.w_held ? st.w_data : i_wdata[7:0];
        ra = i_araddr[9:0];
        next_st = st;
        // write address and data taken in either order
        if (i_awvalid && o_awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = i_awaddr[9:0];
            if (|i_awaddr[31:10]) begin
                next_st.aw_addr = 10'h3ff;
            end
        end
        if (i_wvalid && o_wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = i_wdata[7:0];
            next_st.w_lane0 = i_wstrb[0];
        end
        if (next_st.aw_held && next_st.w_held && !st.bvalid) begin
            wa = next_st.aw_addr;
            wd = next_st.w_data;
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = addr_known(wa) ? ocdm_pkg::OCDM_RESP_OKAY
                : ocdm_pkg::OCDM_RESP_SLVERR;
            if (next_st.w_lane0) begin
                unique case (wa)
                    ocdm_pkg::OCDM_ADDR_DIV23: next_st.div23 = wd;
                    ocdm_pkg::OCDM_ADDR_CTL4: begin
                        next_st.src = wd[ocdm_pkg::OCDM_SRC_LSB +: 2];
                        next_st.fmt = wd[ocdm_pkg::OCDM_FMT_LSB +: 2];
                        next_st.mode1 = wd[ocdm_pkg::OCDM_MODE1_LSB +: 2];
                        next_st.mode2 = wd[ocdm_pkg::OCDM_MODE2_LSB +: 2];
                    end
                    ocdm_pkg::OCDM_ADDR_DIV4: next_st.div4 = wd;
                    default: begin
                    end
                endcase
            end
        end else if (st.bvalid && i_bready) begin
            next_st.bvalid = 1'b0;
        end
        // read answer one cycle after the address is taken
        if (i_arvalid && o_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = ocdm_pkg::OCDM_RESP_OKAY;
            next_st.rdata = 32'h0000_0000;
            if (|i_araddr[31:10]) begin
                next_st.rresp = ocdm_pkg::OCDM_RESP_SLVERR;
            end else begin
                unique case (ra)
                    ocdm_pkg::OCDM_ADDR_DIV23: next_st.rdata[7:0] = st.div23;
                    ocdm_pkg::OCDM_ADDR_CTL4:
                        next_st.rdata[7:0] = {st.src, st.fmt, st.mode1, st.mode2};
                    ocdm_pkg::OCDM_ADDR_DIV4: next_st.rdata[7:0] = st.div4;
                    default: next_st.rresp = ocdm_pkg::OCDM_RESP_SLVERR;
                endcase
            end
        end else if (st.rvalid && i_rready) begin
            next_st.rvalid = 1'b0;
        end
        // reference choices skip the divider
        next_st.ch4_tick = mux_bypass ? mux_tick : div4_tick;
        // mode fields mean different things per format
        next_st.tail = 2'h0;
        next_st.load = 2'h0;
        next_st.ppin = ocdm_pkg::ocdm_pin_decode(ocdm_pkg::OCDM_PIN_DOWN_Z);
        next_st.npin = ocdm_pkg::ocdm_pin_decode(ocdm_pkg::OCDM_PIN_DOWN_Z);
        unique case (ocdm_pkg::ocdm_fmt_t'(next_st.fmt))
            ocdm_pkg::OCDM_FMT_OFF: begin
            end
            ocdm_pkg::OCDM_FMT_AC_DIFF: next_st.tail = next_st.mode1;
            ocdm_pkg::OCDM_FMT_HCSL: begin
                next_st.tail = next_st.mode1;
                next_st.load = next_st.mode2;
            end
            ocdm_pkg::OCDM_FMT_CMOS: begin
                next_st.ppin = ocdm_pkg::ocdm_pin_decode(next_st.mode1);
                next_st.npin = ocdm_pkg::ocdm_pin_decode(next_st.mode2);
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st <= '0;
            st.div23 <= ocdm_pkg::OCDM_RST_DIV23;
            st.src <= ocdm_pkg::OCDM_RST_SRC;
            st.fmt <= ocdm_pkg::OCDM_RST_FMT;
            st.mode1 <= ocdm_pkg::OCDM_RST_MODE1;
            st.mode2 <= ocdm_pkg::OCDM_RST_MODE2;
            st.div4 <= ocdm_pkg::OCDM_RST_DIV4;
            st.tail <= ocdm_pkg::OCDM_RST_MODE1;
            st.ppin <= 3'h1;
            st.npin <= 3'h1;
        end else begin
            st <= next_st;
        end
    end

    // handshake readies are combinational from held state
    assign o_awready = !st.aw_held && !st.bvalid;
    assign o_wready = !st.w_held && !st.bvalid;
    assign o_arready = !st.rvalid;
    assign o_bvalid = st.bvalid;
    assign o_bresp = st.bresp;
    assign o_rvalid = st.rvalid;
    assign o_rdata = st.rdata;
    assign o_rresp = st.rresp;
    assign o_ch4_tick = st.ch4_tick;
    assign o_ch4_bypass = mux_bypass;
    assign o_ch4_drv_en = st.fmt != 2'h0;
    assign o_ch4_diff = st.fmt == 2'h1;
    assign o_ch4_hcsl = st.fmt == 2'h2;
    assign o_ch4_cmos = st.fmt == 2'h3;
    assign o_ch4_tail_level = st.tail;
    assign o_ch4_hcsl_load = st.load;
    assign o_ch4_pos_pin = st.ppin;
    assign o_ch4_neg_pin = st.npin;
endmodule // ocdm_top

//--- tb.sv
// self-checking bench for the output channel divider and mux slice
`timescale 1ns/1ns
module tb;
    localparam logic [31:0] a_div23 = 32'(ocdm_pkg::OCDM_ADDR_DIV23);
    localparam logic [31:0] a_ctl4 = 32'(ocdm_pkg::OCDM_ADDR_CTL4);
    localparam logic [31:0] a_div4 = 32'(ocdm_pkg::OCDM_ADDR_DIV4);
    localparam logic [1:0] rsp_ok = ocdm_pkg::OCDM_RESP_OKAY;
    localparam logic [1:0] rsp_err = ocdm_pkg::OCDM_RESP_SLVERR;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_awvalid = 1'b0;
    logic i_wvalid = 1'b0;
    logic i_arvalid = 1'b0;
    // responses accepted at once, except in late_accept
    logic i_bready = 1'b1;
    logic i_rready = 1'b1;
    logic [31:0] i_awaddr = 32'h0;
    logic [31:0] i_wdata = 32'h0;
    logic [31:0] i_araddr = 32'h0;
    logic [3:0] src_lv = 4'h0;
    logic i_ref_doubler_en = 1'b0;
    logic i_ch23_src_tick = 1'b0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_ch23_tick, o_ch4_tick;
    logic o_ch4_bypass, o_ch4_drv_en, o_ch4_diff, o_ch4_hcsl, o_ch4_cmos;
    logic [1:0] o_bresp, o_rresp, o_ch4_tail_level, o_ch4_hcsl_load;
    logic [31:0] o_rdata;
    logic [2:0] o_ch4_pos_pin, o_ch4_neg_pin;
    int err_count = 0;
    int cmp_count = 0;
    int ch4_cnt = 0;
    int ch23_cnt = 0;

    always #25 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        if (o_ch4_tick === 1'b1) ch4_cnt++;
        if (o_ch23_tick === 1'b1) ch23_cnt++;
    end

    ocdm_top DUT (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr), .i_awprot(3'h0),
        .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(4'hf),
        .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
        .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr), .i_arprot(3'h0),
        .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .i_first_synth_clock(src_lv[0]), .i_second_synth_clock(src_lv[1]),
        .i_pri_ref_clock(src_lv[2]), .i_sec_ref_clock(src_lv[3]),
        .i_ref_doubler_en(i_ref_doubler_en), .i_ch23_src_tick(i_ch23_src_tick),
        .o_ch23_tick(o_ch23_tick), .o_ch4_tick(o_ch4_tick), .o_ch4_bypass(o_ch4_bypass),
        .o_ch4_drv_en(o_ch4_drv_en), .o_ch4_diff(o_ch4_diff), .o_ch4_hcsl(o_ch4_hcsl),
        .o_ch4_cmos(o_ch4_cmos), .o_ch4_tail_level(o_ch4_tail_level),
        .o_ch4_hcsl_load(o_ch4_hcsl_load), .o_ch4_pos_pin(o_ch4_pos_pin),
        .o_ch4_neg_pin(o_ch4_neg_pin)
    );

    task automatic chk(input logic c, input string m);
        cmp_count++;
        if (c !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
        logic b_ok;
        b_ok = 1'b0;
        i_awaddr <= a;
        i_wdata <= {24'h0, d};
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        for (int n = 0; n < 40 && !b_ok; n++) begin
            @(posedge i_clk);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            b_ok = o_bvalid;
            if (b_ok) chk(o_bresp === er, "write response code");
        end
        chk(b_ok, "no write response");
    endtask

    task automatic rd(input logic [31:0] a, input logic [7:0] ed, input logic [1:0] er);
        logic r_ok;
        r_ok = 1'b0;
        i_araddr <= a;
        i_arvalid <= 1'b1;
        for (int n = 0; n < 40 && !r_ok; n++) begin
            @(posedge i_clk);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            r_ok = o_rvalid;
            if (r_ok) chk(o_rdata === {24'h0, ed} && o_rresp === er, "read data or code");
        end
        chk(r_ok, "no read response");
    endtask

    // tolerance of one pulse when pulses are expected, none when zero are, covers divider phase left from the last run
    task automatic run_src(input int s, input int e, input string m);
        int base;
        int tol;
        base = ch4_cnt;
        tol = (e > 0);
        for (int i = 0; i < 128; i++) begin
            @(posedge i_clk);
            if (i % 4 == 0) src_lv[s] <= ~src_lv[s];
        end
        repeat (8) @(posedge i_clk);
        chk(ch4_cnt - base >= e - tol && ch4_cnt - base <= e + tol, m);
    endtask

    task automatic run23(input logic [7:0] code, input int p, input int e);
        int base;
        wr(a_div23, code, rsp_ok);
        base = ch23_cnt;
        for (int i = 0; i < 2 * p; i++) begin
            @(posedge i_clk);
            i_ch23_src_tick <= (i % 2 == 0);
        end
        repeat (6) @(posedge i_clk);
        chk(ch23_cnt - base >= e - 1 && ch23_cnt - base <= e + 1, "shared divider ratio");
    endtask

    function automatic logic [2:0] pin_exp(input logic [1:0] m);
        case (m)
            2'h0: return 3'h1;
            2'h1: return 3'h0;
            2'h2: return 3'h6;
            default: return 3'h4;
        endcase
    endfunction

    task automatic reg_test();
        rd(a_div23, 8'h03, rsp_ok);
        rd(a_ctl4, 8'h18, rsp_ok);
        rd(a_div4, 8'h02, rsp_ok);
        wr(a_div23, 8'ha5, rsp_ok);
        wr(a_ctl4, 8'hc3, rsp_ok);
        wr(a_div4, 8'h5a, rsp_ok);
        wr(32'h0000_0400, 8'hff, rsp_err);
        rd(32'h0000_0400, 8'h00, rsp_err);
        rd(a_div23, 8'ha5, rsp_ok);
        rd(a_ctl4, 8'hc3, rsp_ok);
        rd(a_div4, 8'h5a, rsp_ok);
    endtask

    // answers left standing a few cycles so the hold checks see them
    task automatic late_accept();
        i_bready <= 1'b0;
        i_rready <= 1'b0;
        i_awaddr <= a_div4;
        i_wdata <= 32'h0000_0011;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_araddr <= a_div23;
        i_arvalid <= 1'b1;
        @(posedge i_clk);
        while (!(o_awready && o_wready && o_arready)) @(posedge i_clk);
        i_awvalid <= 1'b0;
        i_wvalid <= 1'b0;
        i_arvalid <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_bready <= 1'b1;
        i_rready <= 1'b1;
        @(posedge i_clk);
        while (!(o_bvalid && o_rvalid)) @(posedge i_clk);
        chk(o_bresp === rsp_ok && o_rdata === 32'h0000_00a5, "late answers");
        @(posedge i_clk);
        rd(a_div4, 8'h11, rsp_ok);
    endtask

    task automatic decode_all();
        logic [1:0] f;
        logic [1:0] m;
        for (int i = 0; i < 16; i++) begin
            f = i[3:2];
            m = i[1:0];
            wr(a_ctl4, {2'h0, f, m, ~m}, rsp_ok);
            repeat (3) @(posedge i_clk);
            chk(o_ch4_drv_en === (f != 2'h0) && o_ch4_hcsl === (f == 2'h2), "format");
            chk(o_ch4_cmos === (f == 2'h3) && o_ch4_diff === (f == 2'h1), "fmt");
            chk(o_ch4_tail_level === ((f == 2'h1 || f == 2'h2) ? m : 2'h0), "tail");
            chk(o_ch4_pos_pin === ((f == 2'h3) ? pin_exp(m) : 3'h1), "positive pin");
            chk(o_ch4_hcsl_load === ((f == 2'h2) ? ~m : 2'h0), "hcsl load");
            chk(o_ch4_neg_pin === ((f == 2'h3) ? pin_exp(~m) : 3'h1), "negative pin");
        end
    endtask

    task automatic src_test();
        wr(a_div4, 8'h00, rsp_ok);
        for (int s = 0; s < 4; s++) begin
            wr(a_ctl4, {s[1:0], 6'h22}, rsp_ok);
            run_src(s, 16, "selected source");
            run_src((s + 1) % 4, 0, "unselected source");
            chk(o_ch4_bypass === (s >= 2), "bypass flag");
        end
    endtask

    task automatic div_test();
        wr(a_ctl4, 8'h22, rsp_ok);
        wr(a_div4, 8'h03, rsp_ok);
        run_src(0, 4, "divide by four");
        wr(a_div4, 8'h01, rsp_ok);
        wr(a_ctl4, 8'h62, rsp_ok);
        run_src(1, 8, "divide by two");
        wr(a_ctl4, 8'ha2, rsp_ok);
        run_src(2, 16, "reference not divided");
        i_ref_doubler_en <= 1'b1;
        run_src(2, 32, "doubled primary");
        wr(a_ctl4, 8'he2, rsp_ok);
        run_src(3, 32, "doubled secondary");
        i_ref_doubler_en <= 1'b0;
        run23(8'h00, 20, 20);
        run23(8'h02, 30, 10);
        run23(8'hff, 512, 2);
    endtask

    task automatic end_of_test();
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        reg_test();
        late_accept();
        decode_all();
        src_test();
        div_test();
        end_of_test();
    end

    // whole run is near 3100 cycles
    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        end_of_test();
    end
endmodule // tb

bind ocdm_top ocdm_sva u_sva (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_rdata(o_rdata), .o_ch4_tick(o_ch4_tick), .o_ch4_drv_en(o_ch4_drv_en),
    .o_ch4_diff(o_ch4_diff), .o_ch4_hcsl(o_ch4_hcsl), .o_ch4_cmos(o_ch4_cmos),
    .o_ch4_tail_level(o_ch4_tail_level), .o_ch4_hcsl_load(o_ch4_hcsl_load),
    .o_ch4_pos_pin(o_ch4_pos_pin), .o_ch4_neg_pin(o_ch4_neg_pin)
);
